// File: logic/prsb_host.sv
// controller end: AXI4-Lite register slave driving the queue link
`timescale 1ns/1ps
module prsb_host (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link to the device
  prsb_link_if.host lnk
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] wdata;
    logic wr_en;
    logic [prsb_pkg::QW-1:0] wr_queue;
    logic [prsb_pkg::DW-1:0] wr_out;
    logic rd_en;
    logic [7:0] addr;
    logic qload;
    logic sload;
    prsb_pkg::prsb_hseq_t seq;
    logic [prsb_pkg::NQ-1:0][1:0] plen;
    logic [prsb_pkg::NQ-1:0] popen;
    logic err;
    logic [prsb_pkg::DW-1:0] rx;
    logic rxv;
    logic [7:0] bus;
    logic sync;
    logic rdy_n;
  } prsb_host_st_t;

  prsb_host_st_t q;
  prsb_host_st_t d;
  logic [31:0] wmask;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [prsb_pkg::QW-1:0] cq;
  logic sop;
  logic eop;

  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wa = {s_axi_awaddr[7:2], 2'b00};
  assign ra = {s_axi_araddr[7:2], 2'b00};
  assign cq = s_axi_wdata[prsb_pkg::QW-1:0];
  assign sop = s_axi_wdata[prsb_pkg::WCTL_SOP];
  // end word must be at least the fourth of an open packet; start and end
  // share no word; a stray end outside a packet passes as filler
  assign eop = s_axi_wdata[prsb_pkg::WCTL_EOP] && !sop
    && (!q.popen[cq] || q.plen[cq] == prsb_pkg::MIN_PKT_M1);

  always_comb begin
    d = q;
    d.awready = 1'b0;
    d.wready = 1'b0;
    d.arready = 1'b0;
    d.wr_en = 1'b0;
    d.rd_en = 1'b0;
    d.qload = 1'b0;
    d.sload = 1'b0;
    d.bus = lnk.packet_ready_bus_n;
    d.sync = lnk.status_bus_sync;
    d.rdy_n = lnk.packet_ready_flag_n;
    case (q.seq)
      prsb_pkg::HS_READ: begin
        d.rd_en = 1'b1;
        d.seq = prsb_pkg::HS_IDLE;
      end
      default: begin
        d.seq = prsb_pkg::HS_IDLE;
      end
    endcase
    ////////////////////////////////////////////////////////////////////
    // write channel: take address and data together, then respond
    if (q.bvalid) begin
      d.bvalid = !s_axi_bready;
    end else if (q.awready) begin
      d.bvalid = 1'b1;
      d.bresp = prsb_pkg::RESP_OKAY;
      if (wa == prsb_pkg::REG_WDATA) begin
        d.wdata = (q.wdata & ~wmask) | (s_axi_wdata & wmask);
      end else if (wa == prsb_pkg::REG_WCTL) begin
        d.wr_en = 1'b1;
        d.wr_queue = cq;
        d.wr_out = {eop, sop, 2'b00, q.wdata};
        // a repeated start inside an open packet does not restart the count
        d.plen[cq] = (sop && !q.popen[cq]) ? 2'h1 :
          (q.plen[cq] == prsb_pkg::MIN_PKT_M1 ? q.plen[cq] :
          q.plen[cq] + 2'h1);
        d.popen[cq] = (q.popen[cq] || sop) && !eop;
        if (s_axi_wdata[prsb_pkg::WCTL_EOP] && !eop) begin
          d.err = 1'b1;
        end
      end else if (wa == prsb_pkg::REG_RCTL) begin
        // selection and read go out on separate cycles
        d.addr = {3'h0, cq};
        d.qload = s_axi_wdata[prsb_pkg::RCTL_SEL];
        if (s_axi_wdata[prsb_pkg::RCTL_SEL]) begin
          d.seq = s_axi_wdata[prsb_pkg::RCTL_RD] ?
            prsb_pkg::HS_READ : prsb_pkg::HS_IDLE;
        end else begin
          d.rd_en = s_axi_wdata[prsb_pkg::RCTL_RD];
        end
      end else if (wa == prsb_pkg::REG_SSEL) begin
        // one command per write, so never with a queue selection
        d.addr = s_axi_wdata[7:0];
        d.sload = 1'b1;
      end else begin
        d.bresp = prsb_pkg::RESP_SLVERR;
      end
    end else if (s_axi_awvalid && s_axi_wvalid) begin
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////
    // read channel
    if (q.rvalid) begin
      d.rvalid = !s_axi_rready;
    end else if (q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = prsb_pkg::RESP_OKAY;
      d.rdata = 32'h0;
      if (ra == prsb_pkg::REG_WDATA) begin
        d.rdata = q.wdata;
      end else if (ra == prsb_pkg::REG_RDATA) begin
        d.rdata = q.rx[31:0];
        d.rxv = 1'b0;
      end else if (ra == prsb_pkg::REG_STAT) begin
        d.rdata = {16'h0, q.rx[prsb_pkg::DW-1:32], q.err, q.rxv,
          q.rdy_n, q.sync, q.bus};
        d.err = 1'b0;
      end else begin
        d.rresp = prsb_pkg::RESP_SLVERR;
      end
    end else if (s_axi_arvalid) begin
      d.arready = 1'b1;
    end
    // set after the clears, so a new event is kept
    if (q.awready && wa == prsb_pkg::REG_WCTL
        && s_axi_wdata[prsb_pkg::WCTL_EOP] && !eop) begin
      d.err = 1'b1;
    end
    if (lnk.rd_valid) begin
      d.rx = lnk.rd_data;
      d.rxv = 1'b1;
    end
    if (!aresetn) begin
      d = '0;
      d.bus = prsb_pkg::BUS_IDLE;
      d.rdy_n = 1'b1;
      d.seq = prsb_pkg::HS_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign lnk.wr_en = q.wr_en;
  assign lnk.wr_queue = q.wr_queue;
  assign lnk.wr_data = q.wr_out;
  assign lnk.rd_en = q.rd_en;
  assign lnk.read_address_bus = q.addr;
  assign lnk.rd_queue_load = q.qload;
  assign lnk.status_word_load = q.sload;
endmodule : prsb_host

// File: shared/prsb_pkg.sv
// constants and types shared by both ends of the packet-ready status link
package prsb_pkg;
  localparam int DW = 36;
  localparam int SOP_BIT = 34;
  localparam int EOP_BIT = 35;
  localparam int NQ = 32;
  localparam int QW = 5;
  localparam int NQW = 6;
  localparam int DEPTH = 8;
  localparam int PW = 3;
  localparam int CW = 4;
  localparam int SW = 8;
  localparam int SW_LOG = 3;
  localparam int ID_LSB = 5;
  localparam int WORD_W = 2;
  localparam logic [PW:0] AE_OFFSET = 4'h2;
  localparam logic [7:0] BUS_IDLE = 8'hFF;
  localparam logic [1:0] MIN_PKT_M1 = 2'h3;
  // controller register map, byte offsets
  localparam logic [7:0] REG_WDATA = 8'h00;
  localparam logic [7:0] REG_WCTL = 8'h04;
  localparam logic [7:0] REG_RCTL = 8'h08;
  localparam logic [7:0] REG_SSEL = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam int WCTL_SOP = 8;
  localparam int WCTL_EOP = 9;
  localparam int RCTL_SEL = 8;
  localparam int RCTL_RD = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {
    HS_IDLE = 1'b0,
    HS_READ = 1'b1
  } prsb_hseq_t;
endpackage : prsb_pkg

// File: shared/prsb_link_if.sv
// link between the controller end and the queue device end
`timescale 1ns/1ps
interface prsb_link_if (
  input wire logic aclk
);
  logic wr_en;
  logic [prsb_pkg::QW-1:0] wr_queue;
  logic [prsb_pkg::DW-1:0] wr_data;
  logic rd_en;
  logic [7:0] read_address_bus;
  logic rd_queue_load;
  logic status_word_load;
  logic [prsb_pkg::DW-1:0] rd_data;
  logic rd_valid;
  logic packet_ready_flag_n;
  logic almost_empty_flag_n;
  logic [7:0] packet_ready_bus_n_drv;
  logic packet_ready_bus_n_oe_n;
  logic [7:0] packet_ready_bus_n;
  logic status_bus_sync;
  logic token_out;
  logic token_in;
  // pulled-up shared bus, one driver shown here
  assign packet_ready_bus_n = packet_ready_bus_n_oe_n ?
    prsb_pkg::BUS_IDLE : packet_ready_bus_n_drv;
  modport dev (
    input wr_en, wr_queue, wr_data, rd_en, read_address_bus,
    input rd_queue_load, status_word_load, token_in,
    output rd_data, rd_valid, packet_ready_flag_n, almost_empty_flag_n,
    output packet_ready_bus_n_drv, packet_ready_bus_n_oe_n,
    output status_bus_sync, token_out
  );
  modport host (
    output wr_en, wr_queue, wr_data, rd_en, read_address_bus,
    output rd_queue_load, status_word_load,
    input rd_data, rd_valid, packet_ready_flag_n, packet_ready_bus_n,
    input status_bus_sync
  );
endinterface : prsb_link_if

// File: logic/prsb_qmem.sv
// per-queue word storage with registered read port
`timescale 1ns/1ps
module prsb_qmem (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic wr_en,
  input wire logic [prsb_pkg::QW-1:0] wr_q,
  input wire logic [prsb_pkg::DW-1:0] wr_data,
  // read side
  input wire logic rd_en,
  input wire logic [prsb_pkg::QW-1:0] rd_q,
  output logic [prsb_pkg::DW-1:0] rd_data,
  output logic rd_valid,
  // occupancy of every queue
  output logic [prsb_pkg::NQ-1:0][prsb_pkg::PW:0] fill
);
  typedef struct packed {
    logic [prsb_pkg::NQ-1:0][prsb_pkg::DEPTH-1:0][prsb_pkg::DW-1:0] mem;
    logic [prsb_pkg::NQ-1:0][prsb_pkg::PW:0] wp;
    logic [prsb_pkg::NQ-1:0][prsb_pkg::PW:0] rp;
    logic [prsb_pkg::DW-1:0] rdata;
    logic rvalid;
  } prsb_qmem_st_t;

  prsb_qmem_st_t q;
  prsb_qmem_st_t d;

  for (genvar i = 0; i < prsb_pkg::NQ; i++) begin : g_fill
    assign fill[i] = q.wp[i] - q.rp[i];
  end

  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    // a write into a full queue is dropped
    if (wr_en && fill[wr_q] != prsb_pkg::DEPTH) begin
      d.mem[wr_q][q.wp[wr_q][prsb_pkg::PW-1:0]] = wr_data;
      d.wp[wr_q] = q.wp[wr_q] + 1'b1;
    end
    if (rd_en && fill[rd_q] != '0) begin
      d.rdata = q.mem[rd_q][q.rp[rd_q][prsb_pkg::PW-1:0]];
      d.rp[rd_q] = q.rp[rd_q] + 1'b1;
      d.rvalid = 1'b1;
    end
    if (!aresetn) begin
      d = '0;
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  assign rd_data = q.rdata;
  assign rd_valid = q.rvalid;
endmodule : prsb_qmem

// File: logic/prsb_dev.sv
// queue device end: packet counters, ready flags and status bus
`timescale 1ns/1ps
module prsb_dev (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link to the controller
  prsb_link_if.dev lnk,
  // straps, taken while reset is held
  input wire logic master_select,
  input wire logic flag_bus_mode_select,
  input wire logic packet_mode_select,
  input wire logic device_position_bit0,
  input wire logic device_position_bit1,
  input wire logic device_position_bit2,
  input wire logic [prsb_pkg::NQW-1:0] queues_configured
);
  typedef struct packed {
    logic packet_mode;
    logic poll_mode;
    logic master;
    logic [2:0] pos;
    logic [prsb_pkg::NQW-1:0] nq;
    logic started;
    logic [prsb_pkg::NQ-1:0] in_pkt;
    logic [prsb_pkg::NQ-1:0] out_pkt;
    logic [prsb_pkg::NQ-1:0][prsb_pkg::CW-1:0] cnt;
    logic [prsb_pkg::NQ-1:0] st;
    logic [prsb_pkg::QW-1:0] rq;
    logic [prsb_pkg::QW-1:0] lastq;
    logic [prsb_pkg::WORD_W-1:0] wsel;
    logic drive;
    logic tok;
    logic [prsb_pkg::WORD_W-1:0] pcnt;
    logic [7:0] bus;
    logic oe_n;
    logic sync;
    logic tok_out;
    logic rdy_n;
    logic ae_n;
  } prsb_dev_st_t;

  prsb_dev_st_t q;
  prsb_dev_st_t d;

  logic [prsb_pkg::NQ-1:0][prsb_pkg::PW:0] fill;
  logic [prsb_pkg::NQ-1:0][prsb_pkg::CW-1:0] cnt_nx;
  logic [prsb_pkg::NQ-1:0] inc;
  logic [prsb_pkg::NQ-1:0] wsop;
  logic [prsb_pkg::NQ-1:0] dec;
  logic [prsb_pkg::NQ-1:0] rx_end_marker;
  logic [prsb_pkg::NQ-1:0] st_nx;
  logic wr_ok;
  logic rd_ok;
  logic eop_fly;
  logic grant;
  logic [2:0] nw;
  logic [prsb_pkg::WORD_W-1:0] w;

  ////////////////////////////////////////////////////////////////////////
  // word storage

  prsb_qmem i_prsb_qmem (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(lnk.wr_en),
    .wr_q(lnk.wr_queue),
    .wr_data(lnk.wr_data),
    .rd_en(rd_ok),
    .rd_q(q.rq),
    .rd_data(lnk.rd_data),
    .rd_valid(lnk.rd_valid),
    .fill(fill)
  );

  assign wr_ok = lnk.wr_en && fill[lnk.wr_queue] != prsb_pkg::DEPTH;

  // an end word already on its way out closes the packet one edge early,
  // so the next read cannot slip into a partial packet
  assign eop_fly = lnk.rd_valid && q.lastq == q.rq && q.out_pkt[q.rq]
    && lnk.rd_data[prsb_pkg::EOP_BIT];

  assign rd_ok = lnk.rd_en && fill[q.rq] != '0 && (!q.packet_mode
    || q.cnt[q.rq] != '0 || (q.out_pkt[q.rq] && !eop_fly));

  ////////////////////////////////////////////////////////////////////////
  // per-queue marker tracking

  for (genvar i = 0; i < prsb_pkg::NQ; i++) begin : g_q
    assign wsop[i] = wr_ok && lnk.wr_queue == prsb_pkg::QW'(i)
      && lnk.wr_data[prsb_pkg::SOP_BIT] && !q.in_pkt[i];
    assign inc[i] = wr_ok && lnk.wr_queue == prsb_pkg::QW'(i)
      && lnk.wr_data[prsb_pkg::EOP_BIT] && q.in_pkt[i];
    assign dec[i] = lnk.rd_valid && q.lastq == prsb_pkg::QW'(i)
      && lnk.rd_data[prsb_pkg::SOP_BIT] && !q.out_pkt[i];
    assign rx_end_marker[i] = lnk.rd_valid && q.lastq == prsb_pkg::QW'(i)
      && lnk.rd_data[prsb_pkg::EOP_BIT] && q.out_pkt[i];
    assign cnt_nx[i] = q.cnt[i] + prsb_pkg::CW'(inc[i])
      - prsb_pkg::CW'(dec[i]);
    // unconfigured queues read as inactive high
    assign st_nx[i] = prsb_pkg::NQW'(i) >= q.nq || (q.packet_mode ?
      q.cnt[i] == '0 : fill[i] > prsb_pkg::AE_OFFSET);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    nw = 3'(({1'b0, q.nq} + 7'(prsb_pkg::SW - 1)) >> prsb_pkg::SW_LOG);
    grant = lnk.token_in || (q.master && !q.started);
    w = '0;
    d.tok_out = 1'b0;
    d.in_pkt = (q.in_pkt | wsop) & ~inc;
    d.out_pkt = (q.out_pkt | dec) & ~rx_end_marker;
    d.cnt = cnt_nx;
    // status takes one stage after the counters: two clocks from the
    // write edge, three from the read edge in packet mode and two in word mode, through the output register
    d.st = st_nx;
    if (rd_ok) begin
      d.lastq = q.rq;
    end
    // queue switch on the read side may delay the flag one clock
    if (lnk.rd_queue_load) begin
      d.rq = lnk.read_address_bus[prsb_pkg::QW-1:0];
    end
    d.rdy_n = q.packet_mode ? q.st[q.rq] : 1'b1;
    d.ae_n = q.packet_mode ? 1'b1 : q.st[q.rq];
    if (q.poll_mode) begin
      if (q.tok || grant) begin
        w = grant ? '0 : q.pcnt;
        d.started = 1'b1;
        d.bus = q.st[prsb_pkg::SW * w +: prsb_pkg::SW];
        d.oe_n = 1'b0;
        d.sync = w == '0;
        d.pcnt = w + 1'b1;
        if (3'(w) + 3'h1 == nw) begin
          d.tok = 1'b0;
          d.tok_out = 1'b1;
        end else begin
          d.tok = 1'b1;
        end
      end else begin
        d.bus = prsb_pkg::BUS_IDLE;
        d.oe_n = 1'b1;
        d.sync = 1'b0;
      end
    end else begin
      if (q.nq <= prsb_pkg::NQW'(prsb_pkg::SW)) begin
        d.drive = 1'b1;
        d.wsel = '0;
      end else if (lnk.status_word_load) begin
        d.drive = lnk.read_address_bus[7:prsb_pkg::ID_LSB] == q.pos;
        d.wsel = lnk.read_address_bus[prsb_pkg::WORD_W-1:0];
      end
      // bit changes landing with a word switch show one clock later
      d.bus = d.drive ? q.st[prsb_pkg::SW * d.wsel +: prsb_pkg::SW]
        : prsb_pkg::BUS_IDLE;
      d.oe_n = !d.drive;
      d.sync = 1'b0;
    end
    if (!aresetn) begin
      d = '0;
      d.packet_mode = packet_mode_select;
      d.poll_mode = flag_bus_mode_select;
      d.master = master_select;
      d.pos = {device_position_bit2, device_position_bit1,
        device_position_bit0};
      d.nq = queues_configured;
      d.st = '1;
      d.bus = prsb_pkg::BUS_IDLE;
      d.oe_n = 1'b1;
      d.rdy_n = 1'b1;
      d.ae_n = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign lnk.packet_ready_bus_n_drv = q.bus;
  assign lnk.packet_ready_bus_n_oe_n = q.oe_n;
  assign lnk.status_bus_sync = q.sync;
  assign lnk.token_out = q.tok_out;
  assign lnk.packet_ready_flag_n = q.rdy_n;
  assign lnk.almost_empty_flag_n = q.ae_n;
endmodule : prsb_dev

// File: verif/prsb_link_properties.sv
// concurrent checks on the link between controller end and device end
`timescale 1ns/1ps
module prsb_link_properties #(
  parameter logic [2:0] POS = 3'h5
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // controller side
  input wire logic rd_en,
  input wire logic [7:0] read_address_bus,
  input wire logic rd_queue_load,
  input wire logic status_word_load,
  // device side
  input wire logic rd_valid,
  input wire logic packet_ready_bus_n_oe_n,
  input wire logic status_bus_sync,
  input wire logic token_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  sequence s_word_hit;
    status_word_load && read_address_bus[7:5] == POS;
  endsequence
  sequence s_word_miss;
    status_word_load && read_address_bus[7:5] != POS;
  endsequence
  // valid for one looped device with four status words
  sequence s_rest_of_ring;
    !token_out [*3] ##1 token_out;
  endsequence
  ////////////////////////////////////////////////////////////
  AST_ONE_LOAD_A_CYCLE: assert property (
    !(rd_queue_load && status_word_load))
    else $error("queue and status word selected together");
  AST_READ_NEEDS_REQUEST: assert property (
    rd_valid |-> $past(rd_en))
    else $error("read data without a read request");
  AST_SYNC_DRIVES_BUS: assert property (
    status_bus_sync |-> !packet_ready_bus_n_oe_n)
    else $error("sync high while bus released");
  AST_FOUR_WORDS: assert property (
    status_bus_sync |=> !status_bus_sync [*3] ##1 status_bus_sync)
    else $error("polled cycle is not four words");
  AST_TOKEN_AFTER_LAST: assert property (
    status_bus_sync |-> s_rest_of_ring)
    else $error("token not passed after last word");
  AST_TOKEN_RETURNS: assert property (
    token_out |=> status_bus_sync)
    else $error("looped token did not restart the cycle");
  AST_WORD_HIT: assert property (
    s_word_hit |=> !packet_ready_bus_n_oe_n)
    else $error("selected word not driven");
  AST_WORD_MISS: assert property (
    s_word_miss |=> packet_ready_bus_n_oe_n)
    else $error("bus driven for another position");
endmodule : prsb_link_properties

// File: verif/tb_prsb.sv
// self-checking bench for controller and device ends joined by the link
`timescale 1ns/1ps
module tb_prsb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic master_sel = 1'b0;
  logic poll_sel = 1'b0;
  logic pmode = 1'b1;
  logic [2:0] pos = 3'h5;
  logic [5:0] nq = 6'h20;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  always #5 aclk = ~aclk;
  prsb_link_if lnk (.aclk(aclk));
  assign lnk.token_in = lnk.token_out;
  prsb_host i_prsb_host (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lnk(lnk));
  prsb_dev i_prsb_dev (.aclk(aclk), .aresetn(aresetn), .lnk(lnk),
    .master_select(master_sel), .flag_bus_mode_select(poll_sel),
    .packet_mode_select(pmode), .device_position_bit0(pos[0]),
    .device_position_bit1(pos[1]), .device_position_bit2(pos[2]),
    .queues_configured(nq));
  prsb_link_properties #(.POS(3'h5)) i_prsb_link_properties (
    .aclk(aclk), .aresetn(aresetn), .rd_en(lnk.rd_en),
    .read_address_bus(lnk.read_address_bus),
    .rd_queue_load(lnk.rd_queue_load),
    .status_word_load(lnk.status_word_load), .rd_valid(lnk.rd_valid),
    .packet_ready_bus_n_oe_n(lnk.packet_ready_bus_n_oe_n),
    .status_bus_sync(lnk.status_bus_sync), .token_out(lnk.token_out));
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  // a hung handshake wait is cut short here
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic dut_reset(input logic m, input logic f, input logic k,
                           input logic [2:0] p, input logic [5:0] n);
    @(posedge aclk);
    aresetn <= 1'b0;
    master_sel <= m;
    poll_sel <= f;
    pmode <= k;
    pos <= p;
    nq <= n;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : dut_reset
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw_done;
    logic w_done;
    @(posedge aclk);
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel is released at its own handshake edge
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(36'(bresp), 36'(er));
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
  endtask : axi_rd
  task automatic put(input logic [4:0] q, input logic s, input logic e,
                     input logic [31:0] d);
    axi_wr(prsb_pkg::REG_WDATA, d, prsb_pkg::RESP_OKAY);
    axi_wr(prsb_pkg::REG_WCTL, {22'h0, e, s, 3'h0, q}, prsb_pkg::RESP_OKAY);
  endtask : put
  task automatic rctl(input logic sel, input logic rd, input logic [4:0] q);
    axi_wr(prsb_pkg::REG_RCTL, {22'h0, rd, sel, 3'h0, q},
           prsb_pkg::RESP_OKAY);
  endtask : rctl
  task automatic ssel(input logic [2:0] p, input logic [1:0] w);
    axi_wr(prsb_pkg::REG_SSEL, {24'h0, p, 3'h0, w}, prsb_pkg::RESP_OKAY);
    @(posedge aclk);
  endtask : ssel
  ////////////////////////////////////////////////////////////
  task automatic t_direct();
    logic [31:0] st;
    for (int w = 0; w < 4; w++) begin
      ssel(3'h5, 2'(w));
      chk(36'(lnk.packet_ready_bus_n_oe_n), 36'h0);
      chk(36'(lnk.packet_ready_bus_n), 36'hFF);
    end
    ssel(3'h2, 2'h0);
    chk(36'(lnk.packet_ready_bus_n_oe_n), 36'h1);
    axi_wr(8'h18, 32'h0, prsb_pkg::RESP_SLVERR);
    axi_wr(prsb_pkg::REG_STAT, 32'h0, prsb_pkg::RESP_SLVERR);
    axi_rd(prsb_pkg::REG_STAT, st);
    chk(36'(st[9:0]), 36'h2FF);
    $display("t_direct done");
  endtask : t_direct
  task automatic t_packet();
    logic [31:0] st;
    rctl(1'b1, 1'b0, 5'h2);
    ssel(3'h5, 2'h0);
    put(5'h2, 1'b1, 1'b0, 32'hA1);
    put(5'h2, 1'b1, 1'b0, 32'hB2);
    put(5'h2, 1'b0, 1'b0, 32'hC3);
    // partial packet only, so the read must be refused
    rctl(1'b0, 1'b1, 5'h2);
    axi_rd(prsb_pkg::REG_STAT, st);
    chk(36'(st[10]), 36'h0);
    put(5'h2, 1'b0, 1'b1, 32'hD4);
    repeat (2) @(posedge aclk);
    chk(36'(lnk.packet_ready_bus_n), 36'hFF);
    @(posedge aclk);
    chk(36'(lnk.packet_ready_bus_n), 36'hFB);
    @(posedge aclk);
    chk(36'(lnk.packet_ready_flag_n), 36'h0);
    put(5'h2, 1'b0, 1'b1, 32'hE5);
    $display("t_packet done");
  endtask : t_packet
  task automatic t_drain();
    logic [31:0] st;
    logic [31:0] dv[4] = '{32'hA1, 32'hB2, 32'hC3, 32'hD4};
    logic [3:0] mk[4] = '{4'h4, 4'h4, 4'h0, 4'h8};
    for (int i = 0; i < 4; i++) begin
      rctl(1'b0, 1'b1, 5'h2);
      if (i == 0) begin
        repeat (3) @(posedge aclk);
        chk(36'(lnk.packet_ready_flag_n), 36'h0);
        @(posedge aclk);
        chk(36'(lnk.packet_ready_flag_n), 36'h1);
        chk(36'(lnk.packet_ready_bus_n), 36'hFF);
      end
      axi_rd(prsb_pkg::REG_STAT, st);
      chk(36'({st[15:12], st[10]}), 36'({mk[i], 1'b1}));
      axi_rd(prsb_pkg::REG_RDATA, st);
      chk(36'(st), 36'(dv[i]));
    end
    // the filler end word forms no packet and stays unread
    rctl(1'b0, 1'b1, 5'h2);
    axi_rd(prsb_pkg::REG_STAT, st);
    chk(36'(st[10]), 36'h0);
    $display("t_drain done");
  endtask : t_drain
  task automatic t_small();
    dut_reset(1'b0, 1'b0, 1'b0, 3'h5, 6'h08);
    repeat (3) @(posedge aclk);
    chk(36'(lnk.packet_ready_bus_n_oe_n), 36'h0);
    // word mode: all eight empty queues read as almost empty
    chk(36'(lnk.packet_ready_bus_n), 36'h00);
    chk(36'(lnk.almost_empty_flag_n), 36'h0);
    for (int i = 0; i < 3; i++) begin
      put(5'h0, 1'b0, 1'b0, 32'(i));
    end
    repeat (3) @(posedge aclk);
    chk(36'(lnk.packet_ready_bus_n), 36'h01);
    chk(36'(lnk.almost_empty_flag_n), 36'h1);
    chk(36'(lnk.packet_ready_flag_n), 36'h1);
    $display("t_small done");
  endtask : t_small
  task automatic t_polled();
    dut_reset(1'b1, 1'b1, 1'b1, 3'h0, 6'h20);
    repeat (2) @(posedge aclk);
    chk(36'(lnk.status_bus_sync), 36'h1);
    chk(36'(lnk.packet_ready_bus_n_oe_n), 36'h0);
    @(posedge aclk);
    chk(36'(lnk.status_bus_sync), 36'h0);
    repeat (2) @(posedge aclk);
    chk(36'(lnk.token_out), 36'h1);
    @(posedge aclk);
    chk(36'(lnk.status_bus_sync), 36'h1);
    $display("t_polled done");
  endtask : t_polled
  ////////////////////////////////////////////////////////////
  initial begin
    dut_reset(1'b0, 1'b0, 1'b1, 3'h5, 6'h20);
    t_direct();
    t_packet();
    t_drain();
    t_small();
    t_polled();
    end_sim();
  end
endmodule : tb_prsb
